// ### logic/stpci_pkg.sv
// stpci_pkg: command byte layout, group codes, filter and timing constants
// assumes: used by stpci_top with the package:: prefix, nothing imported
package stpci_pkg;
   // command byte group field
   localparam int GRP_HI = 7;
   localparam int GRP_LO = 6;
   localparam logic [1:0] GRP_START = 2'h0;
   localparam logic [1:0] GRP_CTRL = 2'h1;
   localparam logic [1:0] GRP_RSEL = 2'h2;
   localparam logic [1:0] GRP_OUT = 2'h3;
   // start mode bits
   localparam int SM_HIGH_SPEED = 0;
   localparam int SM_EXT_START = 1;
   localparam int SM_ACCEL = 2;
   localparam int SM_STOP = 3;
   localparam int SM_START = 4;
   localparam int SM_IRQ_STOP = 5;
   // register select bits
   localparam int RS_IRQ_RAMP = 4;
   localparam int RS_IRQ_EXT = 5;
   // reset values
   localparam logic [7:0] START_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h40;
   localparam logic [7:0] RSEL_RST = 8'h80;
   localparam logic [7:0] OUT_RST = 8'hc0;
   // least external start pulse, in reference clock cycles
   localparam int EXT_FILT_CYC = 4;
   localparam logic [2:0] EXT_FILT_MAX = 3'h3;
   // counter width
   localparam int CNT_W = 24;
   // run states
   typedef enum logic [2:0] {
      RUN_IDLE = 3'b000,
      RUN_PEND = 3'b001,
      RUN_CONST = 3'b010,
      RUN_ACCEL = 3'b011,
      RUN_DECEL = 3'b100
   } stpci_run_t;
endpackage : stpci_pkg

// ### logic/stpci_top.sv
// stpci_top: command latches, start/stop sequencing and interrupt logic
// assumes: host write strobe is synchronous to clk; motion inputs are pins
`timescale 1ns/10ps
module stpci_top (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // host command write
   input wire logic cmd_wr,
   input wire logic [7:0] cmd_data,
   // motion side
   input wire logic external_start_in,
   input wire logic end_limit_in,
   input wire logic stop_in,
   input wire logic origin_in,
   input wire logic slow_down_in,
   input wire logic preset_mode,
   input wire logic preset_done,
   input wire logic decel_done,
   input wire logic [23:0] preset_counter,
   input wire logic [23:0] ramp_down_point_reg,
   // command readback
   output logic [7:0] start_cmd,
   output logic [7:0] ctrl_cmd,
   output logic [7:0] rsel_cmd,
   output logic [7:0] out_cmd,
   // motion control
   output logic running,
   output logic use_high_speed,
   output logic accelerate,
   output logic decelerate,
   // status and interrupt
   output logic [2:0] main_status_word,
   output logic irq_n_o,
   output logic irq_n_oe
);
   // reset synchroniser
   logic rst_s1_r;
   logic rst_n_r;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // input synchronisers: pins pass two flops
   logic [4:0] pin_s1_r;
   logic [4:0] pin_s2_r;
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pin_s1_r <= 5'h1f;
         pin_s2_r <= 5'h1f;
      end else begin
         pin_s1_r <= {external_start_in, end_limit_in, stop_in, origin_in, slow_down_in};
         pin_s2_r <= pin_s1_r;
      end
   end
   logic sta_s;
   logic el_low;
   logic stp_low;
   logic org_low;
   logic sd_low;
   assign sta_s = pin_s2_r[4];
   assign el_low = !pin_s2_r[3];
   assign stp_low = !pin_s2_r[2];
   assign org_low = !pin_s2_r[1];
   assign sd_low = !pin_s2_r[0];

   // external start filter: level must hold four clocks
   logic [2:0] filt_cnt_r;
   logic [2:0] filt_cnt_nxt;
   logic sta_filt_r;
   logic sta_filt_nxt;
   logic sta_fall;
   always_comb begin
      filt_cnt_nxt = 3'h0;
      sta_filt_nxt = sta_filt_r;
      if (sta_s != sta_filt_r) begin
         if (filt_cnt_r == stpci_pkg::EXT_FILT_MAX) begin
            sta_filt_nxt = sta_s;
         end else begin
            filt_cnt_nxt = filt_cnt_r + 3'h1;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         filt_cnt_r <= 3'h0;
         sta_filt_r <= 1'b1;
      end else begin
         filt_cnt_r <= filt_cnt_nxt;
         sta_filt_r <= sta_filt_nxt;
      end
   end
   assign sta_fall = sta_filt_r && !sta_filt_nxt;

   // command latches and run state
   logic [7:0] start_r;
   logic [7:0] start_nxt;
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic [7:0] rsel_r;
   logic [7:0] rsel_nxt;
   logic [7:0] out_r;
   logic [7:0] out_nxt;
   stpci_pkg::stpci_run_t run_r;
   stpci_pkg::stpci_run_t run_nxt;
   logic [1:0] grp;
   logic wr_start;
   logic stop_evt;
   logic ext_evt;
   logic ramp_hit;
   logic [7:0] sb;
   assign grp = cmd_data[stpci_pkg::GRP_HI:stpci_pkg::GRP_LO];
   assign wr_start = cmd_wr && (grp == stpci_pkg::GRP_START);
   assign sb = cmd_data;
   assign ramp_hit = preset_counter <= ramp_down_point_reg;

   always_comb begin
      start_nxt = start_r;
      ctrl_nxt = ctrl_r;
      rsel_nxt = rsel_r;
      out_nxt = out_r;
      run_nxt = run_r;
      stop_evt = 1'b0;
      ext_evt = 1'b0;
      // only the addressed group is replaced
      if (cmd_wr) begin
         case (grp)
            stpci_pkg::GRP_START: start_nxt = cmd_data;
            stpci_pkg::GRP_CTRL: ctrl_nxt = cmd_data;
            stpci_pkg::GRP_RSEL: rsel_nxt = cmd_data;
            stpci_pkg::GRP_OUT: out_nxt = cmd_data;
            default: start_nxt = start_r;
         endcase
      end
      case (run_r)
         stpci_pkg::RUN_IDLE: begin
            if (wr_start && sb[stpci_pkg::SM_START] && !sb[stpci_pkg::SM_STOP]) begin
               if (stp_low || el_low || org_low) begin
                  stop_evt = 1'b1; // blocked start still reports stop
               end else if (sb[stpci_pkg::SM_EXT_START]) begin
                  run_nxt = stpci_pkg::RUN_PEND;
               end else if (sb[stpci_pkg::SM_ACCEL]) begin
                  run_nxt = stpci_pkg::RUN_ACCEL;
               end else begin
                  run_nxt = stpci_pkg::RUN_CONST;
               end
            end
         end
         stpci_pkg::RUN_PEND: begin
            if (wr_start && sb[stpci_pkg::SM_STOP]) begin
               run_nxt = stpci_pkg::RUN_IDLE; // stop cancels delayed start
               stop_evt = 1'b1;
            end else if (stp_low || el_low) begin
               run_nxt = stpci_pkg::RUN_IDLE;
               stop_evt = 1'b1;
            end else if (sta_fall) begin
               ext_evt = 1'b1;
               run_nxt = start_r[stpci_pkg::SM_ACCEL] ? stpci_pkg::RUN_ACCEL
                                                      : stpci_pkg::RUN_CONST;
            end
         end
         stpci_pkg::RUN_CONST, stpci_pkg::RUN_ACCEL, stpci_pkg::RUN_DECEL: begin
            if (stp_low || el_low || (org_low && ctrl_r[0]) || (preset_mode && preset_done)) begin
               run_nxt = stpci_pkg::RUN_IDLE;
               stop_evt = 1'b1;
            end else if (wr_start && sb[stpci_pkg::SM_STOP] && !sb[stpci_pkg::SM_START]) begin
               run_nxt = stpci_pkg::RUN_IDLE;
               stop_evt = 1'b1;
            end else if (run_r == stpci_pkg::RUN_CONST) begin
               run_nxt = stpci_pkg::RUN_CONST;
            end else if (wr_start && sb[stpci_pkg::SM_STOP]) begin
               run_nxt = stpci_pkg::RUN_DECEL;
            end else if (run_r == stpci_pkg::RUN_DECEL) begin
               if (decel_done && start_r[stpci_pkg::SM_STOP]) begin
                  run_nxt = stpci_pkg::RUN_IDLE;
                  stop_evt = 1'b1;
               end else if (!sd_low && !(preset_mode && ramp_hit)
                            && !start_r[stpci_pkg::SM_STOP]) begin
                  run_nxt = stpci_pkg::RUN_ACCEL;
               end
            end else if (sd_low || (preset_mode && ramp_hit)) begin
               run_nxt = stpci_pkg::RUN_DECEL;
            end
         end
         default: run_nxt = stpci_pkg::RUN_IDLE;
      endcase
      // start bit reads back zero once stopped
      if (run_nxt == stpci_pkg::RUN_IDLE) begin
         start_nxt[stpci_pkg::SM_START] = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         start_r <= stpci_pkg::START_RST;
         ctrl_r <= stpci_pkg::CTRL_RST;
         rsel_r <= stpci_pkg::RSEL_RST;
         out_r <= stpci_pkg::OUT_RST;
         run_r <= stpci_pkg::RUN_IDLE;
      end else begin
         start_r <= start_nxt;
         ctrl_r <= ctrl_nxt;
         rsel_r <= rsel_nxt;
         out_r <= out_nxt;
         run_r <= run_nxt;
      end
   end

   // interrupt requests: the clearing enable write wins over set
   logic [2:0] req_r;
   logic [2:0] req_nxt;
   logic [2:0] en;
   logic [2:0] set;
   always_comb begin
      en = {rsel_nxt[stpci_pkg::RS_IRQ_EXT], rsel_nxt[stpci_pkg::RS_IRQ_RAMP],
            start_nxt[stpci_pkg::SM_IRQ_STOP]};
      set = {ext_evt, ramp_hit && run_r != stpci_pkg::RUN_IDLE, stop_evt};
      req_nxt = (req_r & en) | (set & en);
   end
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         req_r <= 3'h0;
      end else begin
         req_r <= req_nxt;
      end
   end

   // outputs
   assign start_cmd = start_r;
   assign ctrl_cmd = ctrl_r;
   assign rsel_cmd = rsel_r;
   assign out_cmd = out_r;
   assign running = run_r inside {stpci_pkg::RUN_CONST, stpci_pkg::RUN_ACCEL,
                                  stpci_pkg::RUN_DECEL};
   assign use_high_speed = start_r[stpci_pkg::SM_HIGH_SPEED];
   assign accelerate = run_r == stpci_pkg::RUN_ACCEL;
   assign decelerate = run_r == stpci_pkg::RUN_DECEL;
   assign main_status_word = req_r;
   assign irq_n_o = 1'b0;
   assign irq_n_oe = |req_r;

   // assertions
   stop_irq_set_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      stop_evt && start_nxt[stpci_pkg::SM_IRQ_STOP] |=> req_r[0])
      else $error("stop interrupt not raised");
   enable_clear_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      !rsel_r[stpci_pkg::RS_IRQ_RAMP] |-> !req_r[1])
      else $error("ramp request without enable");
   irq_or_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      irq_n_oe == (req_r != 3'h0))
      else $error("interrupt pin not OR of requests");
   irq_hold_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      req_r[0] && start_r[stpci_pkg::SM_IRQ_STOP] && !cmd_wr |=> irq_n_oe)
      else $error("interrupt dropped while pending");
   ramp_decel_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      run_r == stpci_pkg::RUN_ACCEL && preset_mode && ramp_hit && !stp_low && !el_low
      && !org_low && !preset_done && !cmd_wr |=> decelerate)
      else $error("no deceleration at ramp point");
   const_mode_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      run_r == stpci_pkg::RUN_CONST |=> !decelerate)
      else $error("constant mode decelerated");
   start_clear_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      run_r == stpci_pkg::RUN_IDLE |-> !start_r[stpci_pkg::SM_START])
      else $error("start bit set while stopped");
   group_keep_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      cmd_wr && grp != stpci_pkg::GRP_CTRL |=> $stable(ctrl_r))
      else $error("control latch changed by other group");
   pend_hold_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      run_r == stpci_pkg::RUN_PEND && sta_s && sta_filt_r |=> !running)
      else $error("started without external start");
   pin_drive_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      irq_n_o == 1'b0)
      else $error("interrupt pin drives high");
   // request setting, masking, filter, start/stop sequencing and output routing guards
   ext_irq_set_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      ext_evt && rsel_nxt[stpci_pkg::RS_IRQ_EXT] |=> req_r[2])
      else $error("external start interrupt not raised");
   ramp_irq_set_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      ramp_hit && running && rsel_nxt[stpci_pkg::RS_IRQ_RAMP] |=> req_r[1])
      else $error("ramp interrupt not raised");
   stop_mask_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      !start_r[stpci_pkg::SM_IRQ_STOP] |-> !req_r[0])
      else $error("stop request without enable");
   ext_mask_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      !rsel_r[stpci_pkg::RS_IRQ_EXT] |-> !req_r[2])
      else $error("external request without enable");
   ext_filter_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      $changed(sta_filt_r) |-> $past(filt_cnt_r) == stpci_pkg::EXT_FILT_MAX)
      else $error("external start filter too short");
   pend_abort_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      run_r == stpci_pkg::RUN_PEND && (stp_low || el_low) |=> run_r == stpci_pkg::RUN_IDLE)
      else $error("delayed start not cancelled");
   const_start_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      run_r == stpci_pkg::RUN_IDLE && wr_start && sb[stpci_pkg::SM_START]
      && !sb[stpci_pkg::SM_STOP] && !sb[stpci_pkg::SM_EXT_START] && !sb[stpci_pkg::SM_ACCEL]
      && !stp_low && !el_low && !org_low |=> running && !accelerate)
      else $error("constant start not taken");
   accel_start_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      run_r == stpci_pkg::RUN_IDLE && wr_start && sb[stpci_pkg::SM_START]
      && !sb[stpci_pkg::SM_STOP] && !sb[stpci_pkg::SM_EXT_START] && sb[stpci_pkg::SM_ACCEL]
      && !stp_low && !el_low && !org_low |=> accelerate)
      else $error("accel start not taken");
   stop_cmd_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      running && wr_start && sb[stpci_pkg::SM_STOP] && !sb[stpci_pkg::SM_START] |=> !running)
      else $error("stop command ignored");
   limit_stop_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      running && (stp_low || el_low) |=> !running)
      else $error("stop or limit pin ignored");
   out_route_a: assert property (@(posedge clk) disable iff (!rst_n_r)
      cmd_wr && grp == stpci_pkg::GRP_OUT |=> out_r == $past(cmd_data))
      else $error("output mode byte not latched");
   cov_pend_c: cover property (@(posedge clk) disable iff (!rst_n_r)
      run_r == stpci_pkg::RUN_PEND);
   cov_accel_c: cover property (@(posedge clk) disable iff (!rst_n_r)
      run_r == stpci_pkg::RUN_ACCEL ##[1:20] run_r == stpci_pkg::RUN_DECEL);
   cov_ext_c: cover property (@(posedge clk) disable iff (!rst_n_r) ext_evt);
   cov_stop_irq_c: cover property (@(posedge clk) disable iff (!rst_n_r) req_r[0]);
   cov_ramp_irq_c: cover property (@(posedge clk) disable iff (!rst_n_r) req_r[1]);
endmodule : stpci_top

// ### tb/stpci_host_model.sv
// stpci_host_model: host cpu writing command bytes on the 8-bit bus
// assumes: bench calls put() from one process; writes are single bytes
`timescale 1ns/10ps
module stpci_host_model (
   // clock
   input wire logic clk,
   // command write
   output logic cmd_wr,
   output logic [7:0] cmd_data
);
   // bus idle at time zero
   initial begin
      cmd_wr = 1'b0;
      cmd_data = 8'h00;
   end
   // one write strobe for one cycle, data held with it
   // config groups first, start mode group last; a 0 enable bit clears a request
   task automatic put(input logic [7:0] b);
      @(negedge clk);
      cmd_wr = 1'b1;
      cmd_data = b;
      @(negedge clk);
      cmd_wr = 1'b0;
      cmd_data = ~b; // released bus shows no stale byte
   endtask : put
endmodule : stpci_host_model

// ### tb/tb.sv
// tb: command latching, start/stop sequencing and interrupt checks
// assumes: stpci_top with host model on the command bus, pins driven here
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cmd_wr;
   logic [7:0] cmd_data;
   logic ext_n = 1'b1;
   logic stop_n = 1'b1;
   logic preset_mode = 1'b1;
   logic decel_done = 1'b0;
   logic el_n = 1'b1;
   logic org_n = 1'b1;
   logic sd_n = 1'b1;
   logic pdone = 1'b0;
   logic [23:0] cnt = 24'h000100;
   logic [23:0] point = 24'h000010;
   logic [7:0] start_cmd, ctrl_cmd, rsel_cmd, out_cmd;
   logic running, use_high_speed, accelerate, decelerate;
   logic [2:0] main_status_word;
   logic irq_n_o, irq_n_oe;
   wire logic irq_line;
   wire logic [7:0] st;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   // pulled-up wire-or interrupt line
   assign irq_line = irq_n_oe ? irq_n_o : 1'b1;
   // status view: 0, status[2:0], line, running, accel, decel
   assign st = {1'b0, main_status_word, irq_line, running, accelerate, decelerate};
   always #50 clk = ~clk;
   stpci_host_model stpci_host_model_inst (.clk(clk), .cmd_wr(cmd_wr), .cmd_data(cmd_data));
   stpci_top stpci_top_inst (
      .clk(clk), .nrst(nrst), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
      .external_start_in(ext_n), .end_limit_in(el_n), .stop_in(stop_n),
      .origin_in(org_n), .slow_down_in(sd_n), .preset_mode(preset_mode),
      .preset_done(pdone), .decel_done(decel_done), .preset_counter(cnt),
      .ramp_down_point_reg(point), .start_cmd(start_cmd), .ctrl_cmd(ctrl_cmd),
      .rsel_cmd(rsel_cmd), .out_cmd(out_cmd), .running(running),
      .use_high_speed(use_high_speed), .accelerate(accelerate), .decelerate(decelerate),
      .main_status_word(main_status_word), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe)
   );
   // compare one byte-wide result
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // counts, verdict, end of run
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   // hang guard, far above the fewer than 200 cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         finish_test();
      end
   end
   // main sequence
   initial begin
      repeat (16) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      chk(start_cmd, 8'h00);
      chk(ctrl_cmd, 8'h40);
      chk(rsel_cmd, 8'h80);
      chk(out_cmd, 8'hc0);
      chk(st, 8'h08);
      // group routing by top bits, other groups untouched
      stpci_host_model_inst.put(8'h4a);
      stpci_host_model_inst.put(8'hc5);
      stpci_host_model_inst.put(8'h8c);
      chk(ctrl_cmd, 8'h4a);
      chk(out_cmd, 8'hc5);
      chk(rsel_cmd, 8'h8c);
      chk(start_cmd, 8'h00);
      stpci_host_model_inst.put(8'h40);
      stpci_host_model_inst.put(8'h80);
      // high constant start, stop pin stop with stop interrupt
      stpci_host_model_inst.put(8'h31);
      chk(st, 8'h0c);
      chk({7'h00, use_high_speed}, 8'h01);
      stop_n = 1'b0;
      repeat (5) @(negedge clk);
      chk(st, 8'h10);
      chk(start_cmd, 8'h21);
      stpci_host_model_inst.put(8'h01);
      chk(st, 8'h08);
      stop_n = 1'b1;
      repeat (3) @(negedge clk);
      // accel start, ramp point at equality, decel stop
      stpci_host_model_inst.put(8'h90);
      stpci_host_model_inst.put(8'h15);
      chk(st, 8'h0e);
      chk({7'h00, use_high_speed}, 8'h01);
      cnt = 24'h000010;
      repeat (3) @(negedge clk);
      chk(st, 8'h25);
      stpci_host_model_inst.put(8'h80);
      chk(st, 8'h0d);
      stpci_host_model_inst.put(8'h1d);
      decel_done = 1'b1;
      repeat (3) @(negedge clk);
      chk(st, 8'h08);
      chk(start_cmd, 8'h0d);
      decel_done = 1'b0;
      // constant mode ignores ramp point; plain stop command
      stpci_host_model_inst.put(8'h10);
      repeat (3) @(negedge clk);
      chk(st, 8'h0c);
      chk({7'h00, use_high_speed}, 8'h00);
      stpci_host_model_inst.put(8'h08);
      chk(st, 8'h08);
      // external start held back until the pin goes low
      stpci_host_model_inst.put(8'ha0);
      stpci_host_model_inst.put(8'h12);
      repeat (4) @(negedge clk);
      chk(st, 8'h08);
      chk(start_cmd, 8'h12);
      ext_n = 1'b0;
      repeat (10) @(negedge clk);
      chk(st, 8'h44);
      ext_n = 1'b1;
      stpci_host_model_inst.put(8'h80);
      chk(st, 8'h0c);
      stpci_host_model_inst.put(8'h08);
      chk(st, 8'h08);
      // short external pulse ignored; pending start cancelled by command and pin
      repeat (4) @(negedge clk);
      stpci_host_model_inst.put(8'h12);
      ext_n = 1'b0;
      repeat (2) @(negedge clk);
      ext_n = 1'b1;
      repeat (8) @(negedge clk);
      chk(st, 8'h08);
      stpci_host_model_inst.put(8'h08);
      chk(start_cmd, 8'h08);
      stpci_host_model_inst.put(8'h12);
      stop_n = 1'b0;
      repeat (4) @(negedge clk);
      chk(start_cmd, 8'h02);
      stop_n = 1'b1;
      ext_n = 1'b0;
      repeat (10) @(negedge clk);
      chk(st, 8'h08);
      ext_n = 1'b1;
      // start blocked by end limit still reports stop
      el_n = 1'b0;
      repeat (3) @(negedge clk);
      stpci_host_model_inst.put(8'h30);
      chk(st, 8'h10);
      chk(start_cmd, 8'h20);
      el_n = 1'b1;
      stpci_host_model_inst.put(8'h00);
      chk(st, 8'h08);
      // origin ignored unless enabled in control mode, then stops
      stpci_host_model_inst.put(8'h10);
      org_n = 1'b0;
      repeat (5) @(negedge clk);
      chk(st, 8'h0c);
      stpci_host_model_inst.put(8'h08);
      chk(st, 8'h08);
      org_n = 1'b1;
      stpci_host_model_inst.put(8'h41);
      stpci_host_model_inst.put(8'h30);
      chk(st, 8'h0c);
      org_n = 1'b0;
      repeat (5) @(negedge clk);
      chk(st, 8'h10);
      chk(start_cmd, 8'h20);
      org_n = 1'b1;
      stpci_host_model_inst.put(8'h00);
      chk(st, 8'h08);
      // slow-down decelerates and releases; preset completion stops
      cnt = 24'h000100;
      stpci_host_model_inst.put(8'h35);
      chk(st, 8'h0e);
      sd_n = 1'b0;
      repeat (4) @(negedge clk);
      chk(st, 8'h0d);
      sd_n = 1'b1;
      repeat (4) @(negedge clk);
      chk(st, 8'h0e);
      pdone = 1'b1;
      @(negedge clk);
      chk(st, 8'h10);
      chk(start_cmd, 8'h25);
      pdone = 1'b0;
      stpci_host_model_inst.put(8'h00);
      chk(st, 8'h08);
      // ramp point ignored outside preset operation
      preset_mode = 1'b0;
      cnt = 24'h000010;
      stpci_host_model_inst.put(8'h15);
      repeat (3) @(negedge clk);
      chk(st, 8'h0e);
      stpci_host_model_inst.put(8'h08);
      chk(st, 8'h08);
      preset_mode = 1'b1;
      // reset in mid-run returns latches and state to reset values
      stpci_host_model_inst.put(8'h11);
      chk(st, 8'h0c);
      nrst = 1'b0;
      @(negedge clk);
      chk(st, 8'h08);
      chk(ctrl_cmd, 8'h40);
      chk(start_cmd, 8'h00);
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      stpci_host_model_inst.put(8'h10);
      chk(st, 8'h0c);
      stpci_host_model_inst.put(8'h08);
      chk(st, 8'h08);
      finish_test();
   end
endmodule : tb
